// File: rtl/psc_consts.svh
// constants of the port statistics counter bank
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define PSC_REG_TABLE_SEL   8'h79
`define PSC_REG_TRIGGER     8'h7a
`define PSC_REG_RESULT0     8'h80
`define PSC_REG_RESULT1     8'h81
`define PSC_REG_RESULT2     8'h82
`define PSC_REG_RESULT3     8'h83
`define PSC_REG_SIZE_CTRL   8'h90
// ----------------------------------------
// table selections and reset values
// ----------------------------------------
`define PSC_SEL_PORT_CNT    8'h1c
`define PSC_SEL_DROP_CNT    8'h1d
`define PSC_RST_BYTE        8'h00
// ----------------------------------------
// word layout
// ----------------------------------------
`define PSC_BIT_OVF         31
`define PSC_BIT_VALID       30
`define PSC_CNT_W           30
`define PSC_DROP_W          16
// ----------------------------------------
// indirect address map
// ----------------------------------------
`define PSC_PORT_SPAN       32
`define PSC_PORT_TOP        8'h5f
`define PSC_DROP_LAST       8'h05
`define PSC_DROP_RX_BASE    3
// ----------------------------------------
// frame lengths in octets
// ----------------------------------------
`define PSC_LEN_MIN         11'd64
`define PSC_LEN_STD_MAX     11'd1522
`define PSC_LEN_BIG_MAX     11'd1536
// ----------------------------------------
// per-port counter offsets
// ----------------------------------------
`define PSC_OFF_RX_LO       5'h00
`define PSC_OFF_RX_HI       5'h01
`define PSC_OFF_RX_SHORT    5'h02
`define PSC_OFF_RX_SHORT_B  5'h03
`define PSC_OFF_RX_LONG     5'h04
`define PSC_OFF_RX_LONG_B   5'h05
`define PSC_OFF_RX_SYM      5'h06
`define PSC_OFF_RX_CRC      5'h07
`define PSC_OFF_RX_ODD      5'h08
`define PSC_OFF_RX_CTRL     5'h09
`define PSC_OFF_RX_PAUSE    5'h0a
`define PSC_OFF_RX_BCAST    5'h0b
`define PSC_OFF_RX_MCAST    5'h0c
`define PSC_OFF_RX_UCAST    5'h0d
`define PSC_OFF_RX_BIN      5'h0e
`define PSC_OFF_TX_LO       5'h14
`define PSC_OFF_TX_HI       5'h15
`define PSC_OFF_TX_LATE     5'h16
`define PSC_OFF_TX_PAUSE    5'h17
`define PSC_OFF_TX_BCAST    5'h18
`define PSC_OFF_TX_MCAST    5'h19
`define PSC_OFF_TX_UCAST    5'h1a
`define PSC_OFF_TX_DEFER    5'h1b
`define PSC_OFF_TX_HITS     5'h1c
`define PSC_OFF_TX_EXCESS   5'h1d
`define PSC_OFF_TX_ONE      5'h1e
`define PSC_OFF_TX_MULTI    5'h1f
`endif

// File: rtl/psc_pkg.sv
// types of the port statistics counter bank
package psc_pkg;
	// ----------------------------------------
	// indirect read sequencer
	// ----------------------------------------
	typedef enum logic [0:0] {
		PSC_IDLE    = 1'b0,
		PSC_CAPTURE = 1'b1
	} psc_state_e;
	typedef logic [10:0] psc_len_t;
	typedef logic [29:0] psc_cnt_t;
	typedef logic [15:0] psc_drop_t;
endpackage

// File: rtl/psc_counters.sv
// port statistics counter bank with indirect read over avalon-mm
// Contract
// - three ports, per-port and shared drop groups
// - count in 29:0, overflow in bit 31
// - bit 30 valid; host rereads when zero
// - ports at 0x00, 0x20, 0x40, same layout
// - rx octets low/high priority, bad included
// - count undersize, fragments, oversize by limit
// - count jabbers and bad-symbol legal frames
// - bad crc: whole bytes crc, else alignment
// - count mac control ethertype frames
// - pause needs type, da, opcode, length, crc
// - good rx broadcast, multicast, unicast separately
// - rx length bins, bad frames included
// - tx good octets by priority, pause included
// - count late collisions
// - tx pause and good cast classes
// - count deferred first tries and total collisions
// - excessive, single and multiple collision counts
// - drop counters 16 bits, upper bits reserved
// - drops at 0x100-0x105, tx then rx
// - word msb first in 0x80 to 0x83
// - per-port counter clears when read
// - drop counters never clear, no flags
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`include "psc_consts.svh"
module psc_counters #(
	parameter int PORTS = 3
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	// avalon-mm slave, word addressed
	input  wire logic [7:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// receive frame summary, one pulse per frame
	input  wire logic [PORTS-1:0]      rx_done,
	input  wire logic [PORTS-1:0][10:0] rx_len,
	input  wire logic [PORTS-1:0]      rx_high_prio,
	input  wire logic [PORTS-1:0]      rx_crc_ok,
	input  wire logic [PORTS-1:0]      rx_odd_bits,
	input  wire logic [PORTS-1:0]      rx_sym_err,
	input  wire logic [PORTS-1:0]      rx_ctrl_type,
	input  wire logic [PORTS-1:0]      rx_pause_da,
	input  wire logic [PORTS-1:0]      rx_pause_op,
	input  wire logic [PORTS-1:0]      rx_bcast,
	input  wire logic [PORTS-1:0]      rx_mcast,
	// transmit frame summary, one pulse per frame
	input  wire logic [PORTS-1:0]      tx_done,
	input  wire logic [PORTS-1:0][10:0] tx_len,
	input  wire logic [PORTS-1:0]      tx_ok,
	input  wire logic [PORTS-1:0]      tx_high_prio,
	input  wire logic [PORTS-1:0]      tx_pause,
	input  wire logic [PORTS-1:0]      tx_bcast,
	input  wire logic [PORTS-1:0]      tx_mcast,
	input  wire logic [PORTS-1:0]      tx_deferred,
	input  wire logic [PORTS-1:0]      tx_excess,
	input  wire logic [PORTS-1:0][4:0] tx_hits,
	input  wire logic [PORTS-1:0]      tx_late_hit,
	// resource drops, one pulse per frame
	input  wire logic [PORTS-1:0]      tx_discard,
	input  wire logic [PORTS-1:0]      rx_discard
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// inclusive length window test, used by the length bins from 65 octets up
	function automatic logic in_range(input psc_pkg::psc_len_t len,
		input psc_pkg::psc_len_t lo, input psc_pkg::psc_len_t hi);
		in_range = (len >= lo) && (len <= hi);
	endfunction

	// ----------------------------------------
	// storage and state
	// ----------------------------------------
	psc_pkg::psc_cnt_t   cnt [PORTS][`PSC_PORT_SPAN];
	logic                ovf [PORTS][`PSC_PORT_SPAN];
	psc_pkg::psc_len_t   inc [PORTS][`PSC_PORT_SPAN];
	psc_pkg::psc_drop_t  drop [2*PORTS];
	psc_pkg::psc_state_e state;
	logic [7:0]          table_sel;
	logic [8:0]          rd_addr;
	logic [31:0]         result;
	logic                big_frames;
	logic                wr_take;
	logic                port_hit;
	logic [1:0]          hit_port;
	logic [4:0]          hit_off;
	logic [31:0]         next_result;
	logic [7:0]          next_rd;
	psc_pkg::psc_len_t   limit;

	assign wr_take = avs_write && !avs_waitrequest;
	assign limit   = big_frames ? `PSC_LEN_BIG_MAX : `PSC_LEN_STD_MAX;

	// ----------------------------------------
	// avalon slave
	// ----------------------------------------
	// one wait cycle per access keeps readdata on a flop
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// read decode; unmapped indices read zero
	always_comb begin
		case (avs_address)
			`PSC_REG_TABLE_SEL: next_rd = table_sel;
			`PSC_REG_TRIGGER:   next_rd = rd_addr[7:0];
			`PSC_REG_RESULT0:   next_rd = result[31:24];
			`PSC_REG_RESULT1:   next_rd = result[23:16];
			`PSC_REG_RESULT2:   next_rd = result[15:8];
			`PSC_REG_RESULT3:   next_rd = result[7:0];
			`PSC_REG_SIZE_CTRL: next_rd = {7'h00, big_frames};
			default:            next_rd = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= {24'h00_0000, next_rd};
		end
	end

	// writable control bytes
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			table_sel  <= `PSC_RST_BYTE;
			big_frames <= 1'b0;
		end else if (wr_take) begin
			if (avs_address == `PSC_REG_TABLE_SEL)
				table_sel <= avs_writedata[7:0];
			if (avs_address == `PSC_REG_SIZE_CTRL)
				big_frames <= avs_writedata[0];
		end
	end

	// ----------------------------------------
	// indirect read sequencer
	// ----------------------------------------
	// other table selections belong to other tables and are ignored here
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state   <= psc_pkg::PSC_IDLE;
			rd_addr <= 9'h000;
		end else begin
			case (state)
				psc_pkg::PSC_IDLE: begin
					if (wr_take && avs_address == `PSC_REG_TRIGGER &&
						(table_sel == `PSC_SEL_PORT_CNT ||
						table_sel == `PSC_SEL_DROP_CNT)) begin
						rd_addr <= {table_sel == `PSC_SEL_DROP_CNT,
							avs_writedata[7:0]};
						state   <= psc_pkg::PSC_CAPTURE;
					end
				end
				psc_pkg::PSC_CAPTURE: state <= psc_pkg::PSC_IDLE;
				default:              state <= psc_pkg::PSC_IDLE;
			endcase
		end
	end

	// address split into port and offset
	assign port_hit = !rd_addr[8] && rd_addr[7:0] <= `PSC_PORT_TOP;
	assign hit_port = rd_addr[6:5];
	assign hit_off  = rd_addr[4:0];

	// result word; holes in the port map return zero but valid, drop holes plain zero
	always_comb begin
		next_result = 32'h0000_0000;
		if (rd_addr[8]) begin
			if (rd_addr[7:0] <= `PSC_DROP_LAST)
				next_result[15:0] = drop[rd_addr[2:0]];
		end else if (port_hit) begin
			next_result[29:0] = cnt[hit_port][hit_off];
			next_result[`PSC_BIT_OVF] = ovf[hit_port][hit_off];
			next_result[`PSC_BIT_VALID] = 1'b1;
		end else begin
			next_result[`PSC_BIT_VALID] = 1'b1;
		end
	end

	// valid drops while a fresh read is being fetched; a trigger aimed at another
	// table never captures here, so it must not clear valid or the host rereads forever
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			result <= 32'h0000_0000;
		end else if (state == psc_pkg::PSC_IDLE && wr_take &&
			avs_address == `PSC_REG_TRIGGER &&
			(table_sel == `PSC_SEL_PORT_CNT || table_sel == `PSC_SEL_DROP_CNT)) begin
			result[`PSC_BIT_VALID] <= 1'b0;
		end else if (state == psc_pkg::PSC_CAPTURE) begin
			result <= next_result;
		end
	end

	// ----------------------------------------
	// event classification into increments
	// ----------------------------------------
	always_comb begin
		for (int p = 0; p < PORTS; p++) begin
			for (int i = 0; i < `PSC_PORT_SPAN; i++)
				inc[p][i] = 11'd0;
			if (rx_done[p]) begin
				// octets of every received frame, good or bad
				if (rx_high_prio[p])
					inc[p][`PSC_OFF_RX_HI] = rx_len[p];
				else
					inc[p][`PSC_OFF_RX_LO] = rx_len[p];
				if (rx_len[p] < `PSC_LEN_MIN) begin
					if (rx_crc_ok[p] && !rx_sym_err[p] && !rx_odd_bits[p])
						inc[p][`PSC_OFF_RX_SHORT] = 11'd1;
					else
						inc[p][`PSC_OFF_RX_SHORT_B] = 11'd1;
				end else if (rx_len[p] > limit) begin
					if (rx_crc_ok[p] && !rx_sym_err[p] && !rx_odd_bits[p])
						inc[p][`PSC_OFF_RX_LONG] = 11'd1;
					else
						inc[p][`PSC_OFF_RX_LONG_B] = 11'd1;
				end else if (rx_sym_err[p]) begin
					inc[p][`PSC_OFF_RX_SYM] = 11'd1;
				end else if (!rx_crc_ok[p]) begin
					if (rx_odd_bits[p])
						inc[p][`PSC_OFF_RX_ODD] = 11'd1;
					else
						inc[p][`PSC_OFF_RX_CRC] = 11'd1;
				end else begin
					// good frame of legal size
					if (rx_bcast[p])
						inc[p][`PSC_OFF_RX_BCAST] = 11'd1;
					else if (rx_mcast[p] && !rx_ctrl_type[p])
						inc[p][`PSC_OFF_RX_MCAST] = 11'd1;
					else if (!rx_mcast[p])
						inc[p][`PSC_OFF_RX_UCAST] = 11'd1;
				end
				if (rx_ctrl_type[p])
					inc[p][`PSC_OFF_RX_CTRL] = 11'd1;
				if (rx_ctrl_type[p] && rx_pause_da[p] && rx_pause_op[p] &&
					rx_len[p] >= `PSC_LEN_MIN && rx_crc_ok[p])
					inc[p][`PSC_OFF_RX_PAUSE] = 11'd1;
				// length bins count bad frames too
				if (rx_len[p] == `PSC_LEN_MIN)
					inc[p][`PSC_OFF_RX_BIN] = 11'd1;
				if (in_range(rx_len[p], 11'd65, 11'd127))
					inc[p][`PSC_OFF_RX_BIN + 5'd1] = 11'd1;
				if (in_range(rx_len[p], 11'd128, 11'd255))
					inc[p][`PSC_OFF_RX_BIN + 5'd2] = 11'd1;
				if (in_range(rx_len[p], 11'd256, 11'd511))
					inc[p][`PSC_OFF_RX_BIN + 5'd3] = 11'd1;
				if (in_range(rx_len[p], 11'd512, 11'd1023))
					inc[p][`PSC_OFF_RX_BIN + 5'd4] = 11'd1;
				if (in_range(rx_len[p], 11'd1024, limit))
					inc[p][`PSC_OFF_RX_BIN + 5'd5] = 11'd1;
			end
			if (tx_late_hit[p])
				inc[p][`PSC_OFF_TX_LATE] = 11'd1;
			if (tx_done[p]) begin
				if (tx_ok[p]) begin
					if (tx_high_prio[p])
						inc[p][`PSC_OFF_TX_HI] = tx_len[p];
					else
						inc[p][`PSC_OFF_TX_LO] = tx_len[p];
					if (tx_pause[p])
						inc[p][`PSC_OFF_TX_PAUSE] = 11'd1;
					if (tx_bcast[p])
						inc[p][`PSC_OFF_TX_BCAST] = 11'd1;
					else if (tx_mcast[p])
						inc[p][`PSC_OFF_TX_MCAST] = 11'd1;
					else
						inc[p][`PSC_OFF_TX_UCAST] = 11'd1;
					if (tx_hits[p] == 5'd1)
						inc[p][`PSC_OFF_TX_ONE] = 11'd1;
					else if (tx_hits[p] > 5'd1)
						inc[p][`PSC_OFF_TX_MULTI] = 11'd1;
				end
				if (tx_deferred[p])
					inc[p][`PSC_OFF_TX_DEFER] = 11'd1;
				// the mac reports hits only in half duplex
				inc[p][`PSC_OFF_TX_HITS] = {6'h00, tx_hits[p]};
				if (tx_excess[p])
					inc[p][`PSC_OFF_TX_EXCESS] = 11'd1;
			end
		end
	end

	// ----------------------------------------
	// per-port counters
	// ----------------------------------------
	// a read-clear in the same cycle as an event keeps the event
	always_ff @(posedge ref_clk) begin
		logic [30:0] sum;
		logic        clr;
		sum = 31'h0000_0000;
		clr = 1'b0;
		for (int p = 0; p < PORTS; p++) begin
			for (int i = 0; i < `PSC_PORT_SPAN; i++) begin
				clr = state == psc_pkg::PSC_CAPTURE && port_hit &&
					hit_port == p[1:0] && hit_off == i[4:0];
				sum = {1'b0, clr ? 30'h0000_0000 : cnt[p][i]} +
					{20'h0_0000, inc[p][i]};
				if (sys_rst) begin
					cnt[p][i] <= 30'h0000_0000;
					ovf[p][i] <= 1'b0;
				end else begin
					cnt[p][i] <= sum[29:0];
					ovf[p][i] <= (ovf[p][i] && !clr) || sum[30];
				end
			end
		end
	end

	// ----------------------------------------
	// shared drop counters
	// ----------------------------------------
	// free running, never cleared; software tracks wraps itself
	always_ff @(posedge ref_clk) begin
		for (int p = 0; p < PORTS; p++) begin
			if (sys_rst) begin
				drop[p] <= 16'h0000;
				drop[p + `PSC_DROP_RX_BASE] <= 16'h0000;
			end else begin
				drop[p] <= drop[p] + {15'h0000, tx_discard[p]};
				drop[p + `PSC_DROP_RX_BASE] <=
					drop[p + `PSC_DROP_RX_BASE] + {15'h0000, rx_discard[p]};
			end
		end
	end

endmodule

// File: tb/psc_monitor.sv
// avalon-side checker for the statistics counter bank
module psc_monitor (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// avalon-mm slave
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sel;
	logic [7:0] trig_sel;
	logic       rd_done;
	logic       wr_done;
	logic       mapped;
	assign rd_done = avs_read && !avs_waitrequest;
	assign wr_done = avs_write && !avs_waitrequest;
	assign mapped  = avs_address inside {8'h79, 8'h7a, 8'h80, 8'h81, 8'h82, 8'h83, 8'h90};
	// shadow select; a trigger under an unknown select is ignored, so keep the old one
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sel      <= 8'h00;
			trig_sel <= 8'h00;
		end else if (wr_done && avs_address == 8'h79) begin
			sel <= avs_writedata[7:0];
		end else if (wr_done && avs_address == 8'h7a && (sel == 8'h1c || sel == 8'h1d)) begin
			trig_sel <= sel;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low longer than one cycle");
	chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait");
	chk_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("wait dropped without request");
	chk_rdata_upper: assert property (avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	chk_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	chk_sel_readback: assert property (rd_done && avs_address == 8'h79 |-> avs_readdata[7:0] == sel)
		else $error("table select readback wrong");
	chk_unmapped_zero: assert property (rd_done && !mapped |-> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	chk_drop_high_zero: assert property (rd_done && avs_address inside {8'h80, 8'h81} &&
		trig_sel == 8'h1d |-> avs_readdata == 32'h00000000)
		else $error("drop word upper bytes not zero");
	chk_port_valid: assert property (rd_done && avs_address == 8'h80 && trig_sel == 8'h1c
		|-> avs_readdata[6])
		else $error("port word valid bit clear");
endmodule

bind psc_counters psc_monitor u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest));

// File: tb/psc_host.sv
// host model: avalon master and the indirect counter read sequence
module psc_host (
	// clock
	input wire logic         ref_clk,
	// avalon-mm master
	output logic [7:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	input wire logic [31:0]  avs_readdata,
	input wire logic         avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
	end
	// one access; held until waitrequest is seen low, however long that takes
	task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= {24'h000000, d};
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// select, trigger, then collect msb first; a port-counter word (select 0x1c) not yet valid is reread
	task automatic read_counter(input logic [7:0] sel, input logic [7:0] a,
		output logic [31:0] w);
		logic [7:0] q;
		access(1'b0, 8'h79, sel, q);
		access(1'b0, 8'h7a, a, q);
		do begin
			for (int i = 0; i < 4; i++) begin
				access(1'b1, 8'(8'h80 + i), 8'h00, q);
				w = {w[23:0], q};
			end
		end while (sel == 8'h1c && w[30] !== 1'b1);
	endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the statistics counter bank
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [8:0] OK = 9'h001, ODD = 9'h002, SYM = 9'h004, CTL = 9'h008;
	localparam logic [8:0] DA = 9'h010, OP = 9'h020, BC = 9'h040, MC = 9'h080, HI = 9'h100;
	logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [2:0] rx_done, rx_high_prio, rx_crc_ok, rx_odd_bits, rx_sym_err, rx_ctrl_type;
	logic [2:0] rx_pause_da, rx_pause_op, rx_bcast, rx_mcast, tx_done, tx_ok, tx_high_prio;
	logic [2:0] tx_pause, tx_bcast, tx_mcast, tx_deferred, tx_excess, tx_late_hit;
	logic [2:0] tx_discard, rx_discard;
	logic [2:0][10:0] rx_len, tx_len;
	logic [2:0][4:0] tx_hits;
	int bad_count, checked, cycles;
	logic [7:0] q;
	psc_counters #(.PORTS(3)) DUT (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .rx_done, .rx_len, .rx_high_prio,
		.rx_crc_ok, .rx_odd_bits, .rx_sym_err, .rx_ctrl_type, .rx_pause_da, .rx_pause_op,
		.rx_bcast, .rx_mcast, .tx_done, .tx_len, .tx_ok, .tx_high_prio, .tx_pause, .tx_bcast,
		.tx_mcast, .tx_deferred, .tx_excess, .tx_hits, .tx_late_hit, .tx_discard, .rx_discard);
	psc_host host (.ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// compare, verdict and hang guard
	// ----------------------------------------
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict;
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// the whole run needs under a thousand cycles; this leaves ample slack
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	function automatic logic [31:0] pw(input int c);
		return {2'b01, 30'(c)};
	endfunction
	task automatic ctr(input logic [7:0] sel, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] w;
		host.read_counter(sel, a, w);
		cmp($sformatf("counter %h/%h", sel, a), exp, w);
	endtask
	// ----------------------------------------
	// frame stimulus, one-cycle summary pulses
	// ----------------------------------------
	task automatic send_rx(input int p, input logic [10:0] len, input logic [8:0] f);
		@(posedge ref_clk);
		rx_done[p] <= 1'b1;
		rx_len[p] <= len;
		{rx_high_prio[p], rx_mcast[p], rx_bcast[p], rx_pause_op[p], rx_pause_da[p],
			rx_ctrl_type[p], rx_sym_err[p], rx_odd_bits[p], rx_crc_ok[p]} <= f;
		@(posedge ref_clk);
		rx_done[p] <= 1'b0;
	endtask
	task automatic send_tx(input logic [10:0] len, input logic [6:0] f, input logic [4:0] h);
		@(posedge ref_clk);
		tx_done[2] <= 1'b1;
		tx_len[2] <= len;
		tx_hits[2] <= h;
		{tx_ok[2], tx_high_prio[2], tx_pause[2], tx_bcast[2], tx_deferred[2], tx_excess[2],
			tx_late_hit[2]} <= f;
		@(posedge ref_clk);
		tx_done[2] <= 1'b0;
		tx_late_hit[2] <= 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		host.access(1'b1, 8'h50, 8'h00, q);
		cmp("unmapped", 32'h0, {24'h0, q});
		host.access(1'b0, 8'h79, 8'h1c, q);
		host.access(1'b1, 8'h79, 8'h00, q);
		cmp("select", 32'h1c, {24'h0, q});
	endtask
	task automatic t_rx_good;
		send_rx(1, 11'd64, OK);
		ctr(8'h1c, 8'h20, pw(64));
		ctr(8'h1c, 8'h2e, pw(1));
		ctr(8'h1c, 8'h2d, pw(1));
		ctr(8'h1c, 8'h2e, pw(0));
		send_rx(1, 11'd100, OK | HI | BC);
		ctr(8'h1c, 8'h21, pw(100));
		ctr(8'h1c, 8'h2b, pw(1));
	endtask
	task automatic t_rx_table;
		logic [10:0] ln [14] = '{64, 65, 128, 256, 512, 1024, 1522, 40, 40, 1530, 1530, 100,
			100, 100};
		logic [8:0] fl [14] = '{OK, OK, OK, OK, OK, OK, OK, OK, 0, OK, 0, OK | SYM, 0, ODD};
		logic [7:0] of [14] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h13, 8'h02, 8'h03,
			8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
		for (int i = 0; i < 14; i++) begin
			send_rx(0, ln[i], fl[i]);
			ctr(8'h1c, of[i], pw(1));
		end
		host.access(1'b0, 8'h90, 8'h01, q);
		send_rx(0, 11'd1530, OK);
		ctr(8'h1c, 8'h04, pw(0));
		ctr(8'h1c, 8'h13, pw(1));
		host.access(1'b0, 8'h90, 8'h00, q);
	endtask
	task automatic t_pause;
		send_rx(0, 11'd64, OK | CTL | DA | OP | MC);
		send_rx(0, 11'd64, CTL | DA | OP);
		ctr(8'h1c, 8'h09, pw(2));
		ctr(8'h1c, 8'h0a, pw(1));
		ctr(8'h1c, 8'h0c, pw(0));
		send_rx(0, 11'd80, OK | MC);
		ctr(8'h1c, 8'h0c, pw(1));
	endtask
	task automatic t_tx;
		logic [7:0] ad [9] = '{8'h55, 8'h54, 8'h58, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h56, 8'h57};
		int ex [9] = '{100, 64, 1, 1, 17, 1, 1, 1, 1};
		send_tx(11'd100, 7'b1101101, 5'd1);
		send_tx(11'd200, 7'b0000010, 5'd16);
		send_tx(11'd64, 7'b1010000, 5'd0);
		for (int i = 0; i < 9; i++)
			ctr(8'h1c, ad[i], pw(ex[i]));
		tx_mcast[2] <= 1'b1;
		send_tx(11'd80, 7'b1000000, 5'd3);
		tx_mcast[2] <= 1'b0;
		ctr(8'h1c, 8'h59, pw(1));
		ctr(8'h1c, 8'h5f, pw(1));
		ctr(8'h1c, 8'h5a, pw(1));
	endtask
	// a trigger under another table's select must leave the last word untouched
	task automatic t_foreign;
		host.access(1'b0, 8'h79, 8'h14, q);
		host.access(1'b0, 8'h7a, 8'h57, q);
		host.access(1'b1, 8'h80, 8'h00, q);
		cmp("foreign msb", 32'h40, {24'h0, q});
		host.access(1'b1, 8'h83, 8'h00, q);
		cmp("foreign lsb", 32'h01, {24'h0, q});
	endtask
	task automatic t_drops;
		@(posedge ref_clk);
		tx_discard <= 3'b010;
		rx_discard <= 3'b100;
		@(posedge ref_clk);
		tx_discard <= 3'b000;
		@(posedge ref_clk);
		rx_discard <= 3'b000;
		ctr(8'h1d, 8'h01, 32'h1);
		ctr(8'h1d, 8'h05, 32'h2);
		ctr(8'h1d, 8'h05, 32'h2);
		ctr(8'h1d, 8'h03, 32'h0);
	endtask
	initial begin
		sys_rst = 1'b1;
		{rx_done, rx_high_prio, rx_crc_ok, rx_odd_bits, rx_sym_err, rx_ctrl_type} = '0;
		{rx_pause_da, rx_pause_op, rx_bcast, rx_mcast, tx_done, tx_ok, tx_high_prio} = '0;
		{tx_pause, tx_bcast, tx_mcast, tx_deferred, tx_excess, tx_late_hit} = '0;
		{tx_discard, rx_discard, rx_len, tx_len, tx_hits} = '0;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_rx_good();
		t_rx_table();
		t_pause();
		t_tx();
		t_foreign();
		t_drops();
		give_verdict();
	end
endmodule
